// [design/watchdog_interval_timer.sv]
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
// What this block does
// - watchdog mode when timer_mode_select and timer_run_enable are both one.
// - watchdog overflow asserts the chip-wide internal reset for 518 states.
// - with reset_output_enable, overflow drives reset output low 132 states; else undriven.
// - watchdog reset shares the pin reset vector; only watchdog_reset_flag tells apart.
// - pin reset wins over a simultaneous watchdog reset.
// - mode zero with run enable is interval timer, interrupt on each overflow.
// - overflow_flag sets in the same cycle as the interrupt, one cycle after the internal reset starts.
// - watchdog_reset_flag sets only on overflow with both mode bits one.
// - internal reset clears overflow_flag and leaves watchdog_reset_flag set.
// - in interval mode the interrupt is active whenever overflow_flag is set.
// - counter write colliding with a count pulse wins; increment is lost.
// - run enable zero holds the counter at zero; one counts selected pulses.
// - clock_select picks divide by 2, 32, 64, 128, 256, 512, 2048 or 4096.
// - overflow is the counter wrapping from maximum to zero.
// - counter and control written by word write; upper byte password, lower data.
module watchdog_interval_timer (
    input  wire logic        i_clk,                // 25 MHz system clock
    input  wire logic        i_reset,              // reset input pin, sync, high
    input  wire logic [7:0]  i_address,            // word index
    input  wire logic        i_read,               // avalon read
    input  wire logic        i_write,              // avalon write
    input  wire logic [31:0] i_writedata,          // password and data
    input  wire logic [3:0]  i_byteenable,         // lanes
    output logic      [31:0] o_readdata,           // registered read data
    output logic             o_waitrequest,        // one wait state
    output logic             o_internal_reset,     // chip-wide reset, high
    output logic             o_reset_output_pin,   // open-drain level, low
    output logic             o_reset_output_oe,    // pin driven while high
    output logic             o_interval_interrupt  // interval request, level
);
    localparam int INT_CYC = watchdog_pkg::INT_RESET_CYCLES;
    localparam int EXT_CYC = watchdog_pkg::EXT_RESET_CYCLES;

    count_tick_if tick_port ();

    logic       ack_q;
    logic [7:0] watchdog_counter_q;
    logic       overflow_flag_q;
    logic       timer_mode_select_q;
    logic       timer_run_enable_q;
    logic [2:0] clock_select_q;
    logic       watchdog_reset_flag_q;
    logic       reset_output_enable_q;
    logic       ovf_armed_q;
    logic       watchdog_reset_flag_armed_q;
    logic [31:0] readdata_q;
    logic       fire_rd;
    logic       fire_wr;
    logic       word_wr;
    logic [7:0] wdata;
    logic       cnt_wr;
    logic       ctl_wr;
    logic       rst_clr;
    logic       rst_oe_wr;
    logic       ovf_now;
    logic       wd_ovf;
    logic       ext_active;
    logic       soft_clear;
    logic [7:0] ctrl_view;
    logic [7:0] reset_view;

    // password-checked word write to one index, bus terms passed in so the assigns follow them
    function automatic logic pw_hit(input logic       wr,
                                    input logic [7:0] addr,
                                    input logic [7:0] pass,
                                    input logic [7:0] idx,
                                    input logic [7:0] pw);
        return wr && (addr == idx) && (pass == pw);
    endfunction

    // one wait state, then the transfer completes
    assign o_waitrequest = (i_read || i_write) && !ack_q;
    assign fire_rd       = i_read && ack_q;
    assign fire_wr       = i_write && ack_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (i_read || i_write) && !ack_q;
        end
    end

    // write decode, only complete low-half word writes count
    assign word_wr   = fire_wr && (i_byteenable[1:0] == 2'h3);
    assign wdata     = i_writedata[7:0];
    assign cnt_wr    = pw_hit(word_wr, i_address, i_writedata[15:8],
                              watchdog_pkg::IDX_TIMER_CTRL, watchdog_pkg::PASS_COUNTER);
    assign ctl_wr    = pw_hit(word_wr, i_address, i_writedata[15:8],
                              watchdog_pkg::IDX_TIMER_CTRL, watchdog_pkg::PASS_CONTROL);
    assign rst_clr   = pw_hit(word_wr, i_address, i_writedata[15:8],
                              watchdog_pkg::IDX_RESET_CTRL, watchdog_pkg::PASS_CONTROL)
                       && (wdata == watchdog_pkg::WATCHDOG_RESET_FLAG_CLEAR);
    assign rst_oe_wr = pw_hit(word_wr, i_address, i_writedata[15:8],
                              watchdog_pkg::IDX_RESET_CTRL, watchdog_pkg::PASS_COUNTER);

    // register views with reserved bits as ones
    assign ctrl_view  = {overflow_flag_q, timer_mode_select_q, timer_run_enable_q,
                         watchdog_pkg::CTRL_RSVD, clock_select_q};
    assign reset_view = {watchdog_reset_flag_q, reset_output_enable_q, watchdog_pkg::RESET_RSVD};

    // read data captured in the wait cycle, unmapped reads zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            readdata_q <= 32'h0000_0000;
        end else if (i_read && !ack_q) begin
            case (i_address)
                watchdog_pkg::IDX_TIMER_CTRL: readdata_q <= {24'h00_0000, ctrl_view};
                watchdog_pkg::IDX_COUNTER:    readdata_q <= {24'h00_0000, watchdog_counter_q};
                watchdog_pkg::IDX_RESET_CTRL: readdata_q <= {24'h00_0000, reset_view};
                default:                      readdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign o_readdata = readdata_q;

    // prescaler
    assign tick_port.run          = timer_run_enable_q;
    assign tick_port.clock_select = clock_select_q;

    count_prescaler #(
        .W (watchdog_pkg::PRESCALE_W)
    ) u_prescaler (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .tick_port (tick_port.divider)
    );

    // overflow is a counted wrap, a colliding write suppresses it; pin reset blocks the trigger
    assign ovf_now = timer_run_enable_q && tick_port.tick && !cnt_wr
                     && (watchdog_counter_q == watchdog_pkg::COUNTER_MAX);
    assign wd_ovf  = ovf_now && timer_mode_select_q && !i_reset;

    // reset pulses, both triggered in the overflow cycle
    reset_stretcher #(
        .LEN (INT_CYC)
    ) u_int_pulse (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_start  (wd_ovf),
        .o_active (o_internal_reset)
    );

    reset_stretcher #(
        .LEN (EXT_CYC)
    ) u_ext_pulse (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_start  (wd_ovf && reset_output_enable_q),
        .o_active (ext_active)
    );

    // open-drain: level always low, enable only during the pulse
    assign o_reset_output_pin = 1'b0;
    assign o_reset_output_oe  = ext_active;

    // chip reset as seen by this block, not in the trigger cycle itself
    assign soft_clear = o_internal_reset && !wd_ovf;

    // counter: held at zero when halted, write beats increment
    always_ff @(posedge i_clk) begin
        if (i_reset || soft_clear) begin
            watchdog_counter_q <= watchdog_pkg::COUNTER_RESET;
        end else if (!timer_run_enable_q) begin
            watchdog_counter_q <= watchdog_pkg::COUNTER_RESET;
        end else if (cnt_wr) begin
            watchdog_counter_q <= wdata;
        end else if (tick_port.tick) begin
            watchdog_counter_q <= watchdog_counter_q + 1'b1;
        end
    end

    // control fields, cleared by pin and by watchdog reset
    always_ff @(posedge i_clk) begin
        if (i_reset || soft_clear) begin
            timer_mode_select_q <= 1'b0;
            timer_run_enable_q  <= 1'b0;
            clock_select_q      <= watchdog_pkg::CKS_RESET;
        end else if (ctl_wr) begin
            timer_mode_select_q <= wdata[watchdog_pkg::MODE_BIT];
            timer_run_enable_q  <= wdata[watchdog_pkg::RUN_BIT];
            clock_select_q      <= wdata[watchdog_pkg::CKS_LSB +: watchdog_pkg::CKS_W];
        end
    end

    // overflow flag: set wins, cleared by read-one-then-write-zero or watchdog reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            overflow_flag_q <= 1'b0;
        end else if (ovf_now) begin
            overflow_flag_q <= 1'b1;
        end else if (soft_clear) begin
            overflow_flag_q <= 1'b0;
        end else if (ctl_wr && ovf_armed_q && !wdata[watchdog_pkg::OVF_BIT]) begin
            overflow_flag_q <= 1'b0;
        end
    end

    // clear permission after reading a flag as one
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ovf_armed_q  <= 1'b0;
            watchdog_reset_flag_armed_q <= 1'b0;
        end else begin
            if (fire_rd && i_address == watchdog_pkg::IDX_TIMER_CTRL
                && readdata_q[watchdog_pkg::OVF_BIT]) begin
                ovf_armed_q <= 1'b1;
            end else if (ctl_wr) begin
                ovf_armed_q <= 1'b0;
            end
            if (fire_rd && i_address == watchdog_pkg::IDX_RESET_CTRL
                && readdata_q[watchdog_pkg::WATCHDOG_RESET_FLAG_BIT]) begin
                watchdog_reset_flag_armed_q <= 1'b1;
            end else if (rst_clr) begin
                watchdog_reset_flag_armed_q <= 1'b0;
            end
        end
    end

    // watchdog reset flag: only pin reset or software clears it
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            watchdog_reset_flag_q <= 1'b0;
        end else if (wd_ovf) begin
            watchdog_reset_flag_q <= 1'b1;
        end else if (rst_clr && watchdog_reset_flag_armed_q) begin
            watchdog_reset_flag_q <= 1'b0;
        end
    end

    // reset output enable survives a watchdog reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            reset_output_enable_q <= 1'b0;
        end else if (rst_oe_wr) begin
            reset_output_enable_q <= wdata[watchdog_pkg::RESET_OUTPUT_ENABLE_BIT];
        end
    end

    // interval request follows the flag in interval mode
    assign o_interval_interrupt = overflow_flag_q && !timer_mode_select_q;

    // pulse length helpers for the checks below
    logic [9:0] int_len_q;
    logic [9:0] ext_len_q;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            int_len_q <= 10'h000;
            ext_len_q <= 10'h000;
        end else begin
            int_len_q <= o_internal_reset ? int_len_q + 1'b1 : 10'h000;
            ext_len_q <= o_reset_output_oe ? ext_len_q + 1'b1 : 10'h000;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // checks
    wd_mode_a: assert property (ovf_now && timer_mode_select_q |=> watchdog_reset_flag_q && overflow_flag_q)
        else $error("watchdog overflow did not set both flags");
    int_len_a: assert property ($fell(o_internal_reset) && !$past(i_reset) |-> int_len_q == 10'(INT_CYC))
        else $error("internal reset pulse has wrong length");
    ext_len_a: assert property ($fell(o_reset_output_oe) && !$past(i_reset) |-> ext_len_q == 10'(EXT_CYC))
        else $error("reset output pulse has wrong length");
    ext_gate_a: assert property ($rose(o_reset_output_oe) |-> wd_ovf && reset_output_enable_q)
        else $error("reset output driven without enable or overflow");
    pin_prio_a: assert property (disable iff (1'b0) i_reset |=> !o_internal_reset && !watchdog_reset_flag_q)
        else $error("pin reset did not take priority");
    start_same_a: assert property (wd_ovf |-> o_internal_reset && (o_reset_output_oe == reset_output_enable_q))
        else $error("reset pulses did not start with overflow");
    watchdog_reset_flag_set_a: assert property ($rose(watchdog_reset_flag_q) |-> $past(wd_ovf))
        else $error("watchdog reset flag set without watchdog overflow");
    watchdog_reset_flag_keep_a: assert property (wd_ovf ##1 !wd_ovf |=> !overflow_flag_q && watchdog_reset_flag_q)
        else $error("internal reset handled flags wrongly");
    irq_rise_a: assert property (ovf_now && !timer_mode_select_q |=> o_interval_interrupt && overflow_flag_q)
        else $error("interval overflow raised no interrupt");
    write_win_a: assert property (cnt_wr && timer_run_enable_q && !soft_clear
                                  |=> watchdog_counter_q == $past(i_writedata[7:0]))
        else $error("counter write lost to increment");
    halt_zero_a: assert property (!timer_run_enable_q |=> watchdog_counter_q == 8'h00)
        else $error("halted counter not zero");
    wrap_zero_a: assert property ($rose(overflow_flag_q) |-> watchdog_counter_q == 8'h00)
        else $error("overflow flag without wrap to zero");
    pw_guard_a: assert property (fire_wr && !ctl_wr && !soft_clear && !ovf_now
                           |=> $stable({timer_mode_select_q, timer_run_enable_q, clock_select_q}))
        else $error("control changed without password");

    // scenarios
    wd_reset_c: cover property (wd_ovf && reset_output_enable_q);
    irq_c:      cover property ($rose(o_interval_interrupt));
    sw_clear_c: cover property (overflow_flag_q ##1 !overflow_flag_q && !o_internal_reset);
    collide_c:  cover property (cnt_wr && tick_port.tick);
endmodule

// [common/watchdog_pkg.sv]
package watchdog_pkg;
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_TIMER_CTRL = 8'ha8;  // control write/read, counter write
    localparam logic [7:0] IDX_COUNTER    = 8'ha9;  // counter read
    localparam logic [7:0] IDX_RESET_CTRL = 8'hab;  // reset control read and write
    // passwords in the upper byte of a word write
    localparam logic [7:0] PASS_COUNTER = 8'h5a;
    localparam logic [7:0] PASS_CONTROL = 8'ha5;
    localparam logic [7:0] WATCHDOG_RESET_FLAG_CLEAR   = 8'h00;
    // field positions
    localparam int OVF_BIT   = 7;
    localparam int MODE_BIT  = 6;
    localparam int RUN_BIT   = 5;
    localparam int CKS_LSB   = 0;
    localparam int CKS_W     = 3;
    localparam int WATCHDOG_RESET_FLAG_BIT  = 7;
    localparam int RESET_OUTPUT_ENABLE_BIT = 6;
    // reserved fields read as ones
    localparam logic [1:0] CTRL_RSVD  = 2'h3;
    localparam logic [5:0] RESET_RSVD = 6'h3f;
    // reset values and counter maximum
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] COUNTER_MAX   = 8'hff;
    localparam logic [2:0] CKS_RESET     = 3'h0;
    // pulse lengths in states, one state is one clock
    localparam int CYCLES_PER_STATE   = 1;
    localparam int INT_RESET_STATES   = 518;
    localparam int EXT_RESET_STATES   = 132;
    localparam int INT_RESET_CYCLES   = INT_RESET_STATES * CYCLES_PER_STATE;
    localparam int EXT_RESET_CYCLES   = EXT_RESET_STATES * CYCLES_PER_STATE;
    // prescaler divisions selected by clock_select
    localparam int PRESCALE_W = 12;
    localparam int unsigned CLK_DIV [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
endpackage

// [common/count_tick_if.sv]
`timescale 1ns/100ps
interface count_tick_if;
    logic       run;           // counter enabled
    logic [2:0] clock_select;  // division choice
    logic       tick;          // one-cycle count pulse
    modport timer   (output run, output clock_select, input tick);
    modport divider (input run, input clock_select, output tick);
endinterface

// [design/count_prescaler.sv]
`timescale 1ns/100ps
module count_prescaler #(
    parameter int W = watchdog_pkg::PRESCALE_W
) (
    input wire logic      i_clk,     // system clock
    input wire logic      i_reset,   // sync reset
    count_tick_if.divider tick_port  // run, select in, tick out
);
    logic [W-1:0] div_q;
    logic [W-1:0] last_w;

    // terminal count of the selected division
    assign last_w = W'(watchdog_pkg::CLK_DIV[tick_port.clock_select] - 1);

    // divider held cleared while the counter is halted
    always_ff @(posedge i_clk) begin
        if (i_reset || !tick_port.run) begin
            div_q <= '0;
        end else if (div_q == last_w) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick_port.tick = tick_port.run && (div_q == last_w);
endmodule

// [design/reset_stretcher.sv]
`timescale 1ns/100ps
module reset_stretcher #(
    parameter int LEN = 4
) (
    input  wire logic i_clk,     // system clock
    input  wire logic i_reset,   // sync reset, aborts a pulse
    input  wire logic i_start,   // one-cycle trigger
    output logic      o_active   // high for LEN cycles from trigger
);
    localparam int CW = $clog2(LEN + 1);
    logic [CW-1:0] left_q;

    // remaining cycles after the trigger cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            left_q <= '0;
        end else if (i_start) begin
            left_q <= CW'(LEN - 1);
        end else if (left_q != '0) begin
            left_q <= left_q - 1'b1;
        end
    end

    // active already in the trigger cycle
    assign o_active = i_start || (left_q != '0);
endmodule

// [testbench/reset_line_device.sv]
`timescale 1ns/100ps
module reset_line_device (
    input  wire logic i_clk,         // system clock
    input  wire logic i_clear,       // forget the last pulse length
    input  wire logic i_pin_level,   // level offered by the driver
    input  wire logic i_pin_oe,      // driver enable
    output int        o_low_cycles   // length of the latest low pulse
);
    logic line_level;
    logic was_low_q;

    // open-drain wire with pull-up: a released line reads high
    assign line_level = i_pin_oe ? i_pin_level : 1'b1;

    // external device measures how long its reset input is held low, count starts at one
    always @(posedge i_clk) begin
        was_low_q <= !line_level;
        if (i_clear) begin
            o_low_cycles <= 0;
        end else if (!line_level) begin
            o_low_cycles <= was_low_q ? o_low_cycles + 1 : 1;
        end
    end
endmodule

// [testbench/watchdog_interval_timer_bench.sv]
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end
module watchdog_interval_timer_bench;
    logic        clk, reset, read, write, clear_count;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0]  byteenable;
    logic        waitrequest, internal_reset, pin_level, pin_oe, interrupt;
    int          miscompares, samples_checked, low_cycles, n, div;

    watchdog_interval_timer i_watchdog_interval_timer (
        .i_clk(clk), .i_reset(reset), .i_address(address), .i_read(read), .i_write(write),
        .i_writedata(writedata), .i_byteenable(byteenable), .o_readdata(readdata),
        .o_waitrequest(waitrequest), .o_internal_reset(internal_reset),
        .o_reset_output_pin(pin_level), .o_reset_output_oe(pin_oe), .o_interval_interrupt(interrupt)
    );

    reset_line_device i_reset_line_device (
        .i_clk(clk), .i_clear(clear_count), .i_pin_level(pin_level), .i_pin_oe(pin_oe),
        .o_low_cycles(low_cycles)
    );

    // report counts and the verdict, then stop
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic access(input logic wr, input logic [7:0] idx, input logic [15:0] word,
                          input logic [3:0] be, output logic [31:0] data);
        int k;
        @(posedge clk);
        read       <= !wr;
        write      <= wr;
        address    <= idx;
        writedata  <= {16'h0000, word};
        byteenable <= be;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        data = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        `CHECK(k, 1)                            // one wait state
        if (k == 20) begin
            miscompares++;
            wrap_up();
        end
    endtask

    task automatic wr16(input logic [7:0] idx, input logic [15:0] word);
        access(1'b1, idx, word, 4'hf, rd);
    endtask

    task automatic rd16(input logic [7:0] idx, input logic [31:0] exp);
        access(1'b0, idx, 16'h0000, 4'hf, rd);
        `CHECK(rd, exp)
    endtask

    // bounded wait for the interrupt or the internal reset
    task automatic wait_for(input logic use_reset, input int bound, output int cycles);
        for (cycles = 1; cycles <= bound; cycles++) begin
            @(posedge clk);
            if ((use_reset ? internal_reset : interrupt) === 1'b1) return;
        end
        miscompares++;
        wrap_up();
    endtask

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // main sequence
    initial begin
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        byteenable = 4'h0;
        clear_count = 1'b0;
        miscompares = 0;
        samples_checked = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        // reset values, unmapped index, refused writes
        rd16(8'ha8, 32'h18);
        rd16(8'ha9, 32'h00);
        rd16(8'hab, 32'h3f);
        rd16(8'h00, 32'h00);
        access(1'b1, 8'ha8, 16'h3360, 4'hf, rd);
        access(1'b1, 8'ha8, 16'ha560, 4'h1, rd);
        rd16(8'ha8, 32'h18);
        // interval mode through every clock division
        for (int k = 0; k < 8; k++) begin
            div = int'(watchdog_pkg::CLK_DIV[k]);  // signed copy keeps the lower bound from wrapping
            wr16(8'ha8, {8'ha5, 8'h20 | 8'(k)});
            wr16(8'ha8, {8'h5a, 8'hfe});
            wait_for(1'b0, 2 * div + 40, n);
            `CHECK(n >= div - 4 && n <= 2 * div + 8, 1'b1)
            `CHECK(internal_reset, 1'b0)
            rd16(8'ha8, {24'h0, 8'hb8 | 8'(k)});
            wr16(8'ha8, {8'ha5, 8'h00});
            @(posedge clk);
            `CHECK(interrupt, 1'b0)
        end
        rd16(8'ha9, 32'h00);
        // watchdog overflow with and without the external pulse
        for (int e = 1; e >= 0; e--) begin
            wr16(8'hab, {8'h5a, e ? 8'h40 : 8'h00});
            clear_count <= 1'b1;
            @(posedge clk);
            clear_count <= 1'b0;
            wr16(8'ha8, {8'ha5, 8'h60});
            wr16(8'ha8, {8'h5a, 8'hfe});
            wait_for(1'b1, 40, n);
            `CHECK(pin_oe, e[0])
            `CHECK(interrupt, 1'b0)
            for (n = 1; n < 600; n++) begin
                @(posedge clk);
                if (internal_reset !== 1'b1) break;
            end
            `CHECK(n, 518)
            `CHECK(low_cycles, e ? 132 : 0)
            rd16(8'hab, e ? 32'hff : 32'hbf);
            rd16(8'ha8, 32'h18);
            wr16(8'hab, {8'ha5, 8'h00});
            rd16(8'hab, e ? 32'h7f : 32'h3f);
        end
        // pin reset arriving during a watchdog reset wins
        wr16(8'ha8, {8'ha5, 8'h60});
        wr16(8'ha8, {8'h5a, 8'hfe});
        wait_for(1'b1, 40, n);
        reset <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        `CHECK(internal_reset, 1'b0)
        reset <= 1'b0;
        rd16(8'hab, 32'h3f);
        rd16(8'ha8, 32'h18);
        wrap_up();
    end
endmodule
